// File: eeprom_defs.svh
// How it works
// - Every start is followed by an 8-bit device address byte before any access.
// - Address byte must carry the fixed four-bit type pattern in its top bits.
// - Next three address bits are page select, upper word address bits.
// - Last address bit picks direction: one reads, zero writes.
// - Matching address gets a low acknowledge; mismatch releases bus, goes idle.
// - Byte write: word address then one data byte, each acknowledged.
// - Stop after a write starts the self-timed programming cycle.
// - During programming all inputs are ignored and nothing is acknowledged.
// - Page write accepts up to sixteen bytes, each acknowledged.
// - Write address increments only its low four bits per data byte.
// - Past the page end, writes wrap to the same page start.
// - Polling address byte is acknowledged only after programming has finished.
// - Address counter holds last accessed address plus one between transfers.
// - Read counter wraps from last byte of memory to the first.
// - Current read: acknowledge address, send byte at counter, master nacks, stops.
// - Master acknowledge continues sequential read; nack plus stop ends it.
// - Words are 8 bits; receiver acknowledges low in the ninth clock.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Memory is 128 pages of sixteen bytes with an 11-bit word address.
// - Write-protect high blocks all array writes; reads still work.
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH
`define DEV_TYPE_CODE 4'ha
`define ADDR_W 11
`define MEM_DEPTH 2048
`define PAGE_BITS 4
`define CLK_PERIOD_NS 8
`define PROG_TIME_MS 5
`define PROG_CYCLES ((`PROG_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// File: eeprom_pkg.sv
package eeprom_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_WORDADDR, ST_WDATA, ST_RDATA, ST_MACK, ST_DEVACK} st_t;
endpackage : eeprom_pkg

// File: pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic pin_out
);
    logic meta_ff;
    // Two flip-flops bring a pin into the clock domain; idle high.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_ff <= 1'b1;
            pin_out <= 1'b1;
        end else begin
            meta_ff <= pin_in;
            pin_out <= meta_ff;
        end
    end
endmodule : pin_sync

// File: eeprom_target.sv
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module eeprom_target #(
    parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic wp_in,
    output logic busy
);
    logic scl_s, sda_s, wp_s, scl_d_ff, sda_d_ff;
    eeprom_pkg::st_t st_ff;
    logic [7:0] sh_ff;
    logic [3:0] bit_ff;
    logic ack_ph_ff;
    logic [`ADDR_W-1:0] addr_ff;
    logic [`ADDR_W-1:0] wr_addr_ff;
    logic [2:0] page_ff;
    logic wrote_ff;
    logic [7:0] rd_ff;
    logic drive_ff;
    logic [22:0] prog_cnt_ff;
    logic [7:0] mem [0:`MEM_DEPTH-1];

    // Pin synchronisers for clock, data and write protect.
    pin_sync u_scl (.mclk(mclk), .rst_b(rst_b), .pin_in(scl_in), .pin_out(scl_s));
    pin_sync u_sda (.mclk(mclk), .rst_b(rst_b), .pin_in(sda_in), .pin_out(sda_s));
    pin_sync u_wp (.mclk(mclk), .rst_b(rst_b), .pin_in(wp_in), .pin_out(wp_s));

    // Delayed copies for edge detection.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    // Bus events; the programming cycle masks start detection.
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire prog_busy = (prog_cnt_ff != 23'h0);
    wire start_ev = scl_s & scl_d_ff & ~sda_s & sda_d_ff & ~prog_busy;
    wire stop_ev = scl_s & scl_d_ff & sda_s & ~sda_d_ff;
    wire [7:0] sh_next = {sh_ff[6:0], sda_s};
    wire byte_done = scl_rise & (bit_ff == 4'h7) & ~ack_ph_ff;
    wire addr_match = (sh_next[7:4] == `DEV_TYPE_CODE);
    wire is_read = sh_next[0];
    wire [`ADDR_W-1:0] word_addr = {page_ff, sh_next};
    wire [`ADDR_W-1:0] wr_next = {wr_addr_ff[`ADDR_W-1:`PAGE_BITS],
                                  wr_addr_ff[`PAGE_BITS-1:0] + 4'h1};
    wire [`ADDR_W-1:0] rd_next = addr_ff + 11'h001;
    wire do_write = byte_done & (st_ff == eeprom_pkg::ST_WDATA) & ~wp_s;
    wire start_prog = stop_ev & wrote_ff & ~prog_busy;

    // Programming timer; polling sees no acknowledge until it expires.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prog_cnt_ff <= 23'h0;
        end else if (start_prog) begin
            prog_cnt_ff <= PROG_CYCLES[22:0];
        end else if (prog_busy) begin
            prog_cnt_ff <= prog_cnt_ff - 23'h1;
        end
    end
    assign busy = prog_busy;

    // Array write; words land in the array at the write address directly.
    always_ff @(posedge mclk) begin
        if (do_write) begin
            mem[wr_addr_ff] <= sh_next;
        end
    end

    // Bit counter and shifter; the ninth clock is the acknowledge slot.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bit_ff <= 4'h0;
            sh_ff <= 8'h00;
            ack_ph_ff <= 1'b0;
        end else if (start_ev) begin
            bit_ff <= 4'h0;
            ack_ph_ff <= 1'b0;
        end else if (scl_rise && st_ff != eeprom_pkg::ST_IDLE) begin
            if (ack_ph_ff) begin
                ack_ph_ff <= 1'b0;
                bit_ff <= 4'h0;
            end else begin
                sh_ff <= sh_next;
                if (bit_ff == 4'h7) begin
                    ack_ph_ff <= 1'b1;
                end else begin
                    bit_ff <= bit_ff + 4'h1;
                end
            end
        end
    end

    // Protocol controller.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_ff <= eeprom_pkg::ST_IDLE;
            addr_ff <= 11'h000;
            wr_addr_ff <= 11'h000;
            page_ff <= 3'h0;
            wrote_ff <= 1'b0;
            rd_ff <= 8'h00;
        end else if (start_ev) begin
            st_ff <= eeprom_pkg::ST_DEVADDR;
            wrote_ff <= 1'b0;
        end else if (stop_ev) begin
            st_ff <= eeprom_pkg::ST_IDLE;
            wrote_ff <= 1'b0;
        end else if (byte_done) begin
            unique case (st_ff)
                eeprom_pkg::ST_DEVADDR: begin
                    if (!addr_match) begin
                        st_ff <= eeprom_pkg::ST_IDLE;
                    end else if (is_read) begin
                        st_ff <= eeprom_pkg::ST_DEVACK;
                        rd_ff <= mem[addr_ff];
                    end else begin
                        page_ff <= sh_next[3:1];
                        st_ff <= eeprom_pkg::ST_WORDADDR;
                    end
                end
                eeprom_pkg::ST_WORDADDR: begin
                    addr_ff <= word_addr;
                    wr_addr_ff <= word_addr;
                    st_ff <= eeprom_pkg::ST_WDATA;
                end
                eeprom_pkg::ST_WDATA: begin
                    wrote_ff <= wrote_ff | ~wp_s;
                    wr_addr_ff <= wr_next;
                    addr_ff <= wr_next;
                end
                eeprom_pkg::ST_RDATA: begin
                    st_ff <= eeprom_pkg::ST_MACK;
                end
                default: begin
                end
            endcase
        end else if (scl_rise && ack_ph_ff) begin
            if (st_ff == eeprom_pkg::ST_DEVACK) begin
                st_ff <= eeprom_pkg::ST_RDATA;
                addr_ff <= rd_next;
            end else if (st_ff == eeprom_pkg::ST_MACK) begin
                if (!sda_s) begin
                    rd_ff <= mem[addr_ff];
                    addr_ff <= rd_next;
                    st_ff <= eeprom_pkg::ST_RDATA;
                end else begin
                    st_ff <= eeprom_pkg::ST_IDLE;
                end
            end
        end
    end

    // Output drive chosen on falling clock edges.
    wire ack_slot = ack_ph_ff & (st_ff == eeprom_pkg::ST_WORDADDR || st_ff == eeprom_pkg::ST_WDATA ||
                                 st_ff == eeprom_pkg::ST_DEVACK || st_ff == eeprom_pkg::ST_RDATA);
    wire send_bit = ~ack_ph_ff & (st_ff == eeprom_pkg::ST_RDATA) & ~rd_ff[3'h7 - bit_ff[2:0]];
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            drive_ff <= 1'b0;
        end else if (start_ev || stop_ev || prog_busy) begin
            drive_ff <= 1'b0;
        end else if (scl_fall) begin
            drive_ff <= (ack_slot && st_ff != eeprom_pkg::ST_RDATA) || send_bit;
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = drive_ff;
endmodule : eeprom_target

// File: eeprom_target_asserts.sv
`timescale 1ns/1ps
module eeprom_target_asserts #(
    parameter int unsigned PROG_CYCLES = 200
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wp_in,
    input wire logic busy
);
    int busy_len_ff;
    // Counts consecutive busy cycles so the programming length can be judged.
    always_ff @(posedge mclk) begin
        busy_len_ff <= (!rst_b || !busy) ? 0 : busy_len_ff + 1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Building blocks: a quiet bus and an acknowledge that holds.
    sequence s_bus_idle; scl_in && sda_in; endsequence
    sequence s_held_low; sda_oe [*8]; endsequence
    property p_open_drain; sda_out == 1'b0; endproperty
    property p_reset_quiet; disable iff (1'b0) !rst_b |=> !sda_oe && !busy; endproperty
    property p_busy_mute; busy |-> !sda_oe; endproperty
    property p_edge_safe; $changed(sda_oe) |-> !scl_in; endproperty
    property p_ack_hold; $rose(sda_oe) |-> s_held_low; endproperty
    property p_prog_start; $rose(busy) |-> s_bus_idle; endproperty
    property p_prog_len; $fell(busy) |-> busy_len_ff + 2 >= PROG_CYCLES; endproperty
    property p_protect; $rose(busy) |-> !$past(wp_in, 8); endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    a_busy_mute: assert property (p_busy_mute) else $error("acknowledge while programming");
    a_edge_safe: assert property (p_edge_safe) else $error("data pin moved with clock high");
    a_ack_hold: assert property (p_ack_hold) else $error("low drive too short");
    a_prog_start: assert property (p_prog_start) else $error("programming without stop");
    a_prog_len: assert property (p_prog_len) else $error("programming cycle too short");
    a_protect: assert property (p_protect) else $error("programming while protected");
endmodule : eeprom_target_asserts
bind eeprom_target eeprom_target_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.mclk(mclk), .rst_b(rst_b),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .busy(busy));

// File: bus_master.sv
`timescale 1ns/1ps
module bus_master (
    output logic scl,
    output logic sda,
    input wire logic sda_line
);
    // Clock stands high and data is released between frames.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // One 125 ns bit; data moves only while the clock is low.
    task automatic cyc(input logic b, output logic s);
        sda = b;
        #40 scl = 1'b1;
        #22 s = sda_line;
        #23 scl = 1'b0;
        #40;
    endtask : cyc
    // Start is data falling with the clock high; stop is data rising.
    task automatic start();
        sda = 1'b1;
        #40 scl = 1'b1;
        #60 sda = 1'b0;
        #60 scl = 1'b0;
    endtask : start
    task automatic stop();
        sda = 1'b0;
        #40 scl = 1'b1;
        #60 sda = 1'b1;
        #120;
    endtask : stop
    // Bytes go out MSB first, then the target's answer is taken.
    task automatic tx(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) cyc(b[i], s);
        cyc(1'b1, s);
        ack = ~s;
    endtask : tx
    task automatic rx(input logic mack, output logic [7:0] b);
        logic s;
        for (int i = 0; i < 8; i++) begin
            cyc(1'b1, s);
            b = {b[6:0], s};
        end
        cyc(~mack, s);
    endtask : rx
endmodule : bus_master

// File: serial_eeprom_two_wire_target_bench.sv
`timescale 1ns/1ps
`include "eeprom_defs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module serial_eeprom_two_wire_target_bench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic wp_in = 1'b0;
    logic scl, sda_m, sda_out, sda_oe, busy;
    wire logic sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] mem [0:2047];
    logic [18:0] rows [4] = '{19'h7ffa5, 19'h0003c, 19'h001c3, 19'h3455a};
    eeprom_target #(.PROG_CYCLES(200)) i_eeprom_target (.mclk(mclk), .rst_b(rst_b), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .busy(busy));
    bus_master i_bus_master (.scl(scl), .sda(sda_m), .sda_line(sda_line));
    // Clock and a watchdog that cuts a hang short.
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            wrap_up();
        end
    end
    task wrap_up();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic devb(input logic [10:0] a, input logic r, output logic ack);
        i_bus_master.start();
        i_bus_master.tx({`DEV_TYPE_CODE, a[10:8], r}, ack);
    endtask : devb
    // Writes n bytes, updates the expected image, then polls until acknowledged.
    task automatic wr(input logic [10:0] a, input int n, input logic [7:0] d0);
        logic ack;
        int np;
        devb(a, 1'b0, ack);
        `CHK("dev ack", 1'b1, ack)
        i_bus_master.tx(a[7:0], ack);
        `CHK("word ack", 1'b1, ack)
        for (int i = 0; i < n; i++) begin
            i_bus_master.tx(8'(d0 + i), ack);
            `CHK("data ack", 1'b1, ack)
            if (!wp_in) mem[{a[10:4], 4'(a[3:0] + i)}] = 8'(d0 + i);
        end
        i_bus_master.stop();
        `CHK("busy", !wp_in, busy)
        np = 0;
        do begin
            devb(a, 1'b0, ack);
            np++;
        end while (!ack && np < 50);
        i_bus_master.stop();
        `CHK("poll nack", !wp_in, np > 1)
        `CHK("poll ack", 1'b1, ack)
    endtask : wr
    // Random read unless cur is set, n bytes with master acknowledge between.
    task automatic rd(input logic [10:0] a, input int n, input logic cur);
        logic ack;
        logic [7:0] d;
        if (!cur) begin
            devb(a, 1'b0, ack);
            i_bus_master.tx(a[7:0], ack);
        end
        devb(a, 1'b1, ack);
        `CHK("rd ack", 1'b1, ack)
        for (int i = 0; i < n; i++) begin
            i_bus_master.rx(i < n - 1, d);
            `CHK("rdata", mem[11'(a + i)], d)
        end
        i_bus_master.stop();
    endtask : rd
    // Table rows first, then wraps, page write, bad type, reset and protection.
    initial begin
        logic ack;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        foreach (rows[k]) begin
            wr(rows[k][18:8], 1, rows[k][7:0]);
            rd(rows[k][18:8], 1, 1'b0);
        end
        rd(11'h7ff, 2, 1'b0);
        rd(11'h001, 1, 1'b1);
        wr(11'h120, 18, 8'h10);
        rd(11'h120, 16, 1'b0);
        i_bus_master.start();
        i_bus_master.tx(8'hb0, ack);
        i_bus_master.stop();
        `CHK("bad type", 1'b0, ack)
        @(posedge mclk) rst_b <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(11'h000, 1, 1'b1);
        @(posedge mclk) wp_in <= 1'b1;
        wr(11'h345, 1, 8'h00);
        rd(11'h345, 1, 1'b0);
        wrap_up();
    end
endmodule : serial_eeprom_two_wire_target_bench
